// [design/adcbus_top.sv]
`timescale 1ns/10ps
`include "adcbus_defines.svh"
module adcbus_top #(
  parameter int ACQ_CYC = `ADCBUS_ACQ_CYC,
  parameter int CONV_CYC = `ADCBUS_CONV_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic power_down_in,
  input wire logic conv_start_n,
  input wire logic refbuf_off,
  input wire adcbus_pkg::adcbus_sel_s sel,
  input wire logic [17:0] data_in,
  input wire logic [17:0] sample_in,
  output adcbus_pkg::adcbus_bus_s bus,
  output logic busy,
  output logic refbuf_en,
  output logic powered_down
);
  import adcbus_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers: 3 flops, change accepted when 2nd and 3rd agree
  // ------------------------------------------------------------
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic wsel_raw, bsel_raw, cod_raw;
  assign wsel_raw = data_in[`ADCBUS_LINE_WSEL];
  assign bsel_raw = data_in[`ADCBUS_LINE_BSEL];
  assign cod_raw = data_in[`ADCBUS_LINE_CODING];
  assign pin_raw = {power_down_in, conv_start_n, wsel_raw, bsel_raw, cod_raw};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_comb begin
        filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= `ADCBUS_SYNC_RST;
      s2_r <= `ADCBUS_SYNC_RST;
      s3_r <= `ADCBUS_SYNC_RST;
      filt_r <= `ADCBUS_SYNC_RST;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  logic pd_s, cnv_s, wsel_s, bsel_s, coding_s, cnv_prev_r, cnv_prev_nxt;
  assign {pd_s, cnv_s, wsel_s, bsel_s, coding_s} = filt_r;

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  adcbus_state_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [17:0] result_r, result_nxt;
  logic [17:0] held_r, held_nxt;
  logic pdn_r, pdn_nxt;
  logic cnv_fall, acq_done, start_go;

  assign cnv_fall = cnv_prev_r & ~cnv_s;
  assign acq_done = (cnt_r >= 16'(ACQ_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    result_nxt = result_r;
    held_nxt = held_r;
    pdn_nxt = pdn_r;
    cnv_prev_nxt = cnv_s;
    start_go = 1'b0;
    unique case (st_r)
      ADCBUS_ST_ACQ: begin
        // while powered down, nothing is started
        pdn_nxt = pd_s;
        if (!acq_done) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else if (!pd_s) begin
          if (!cnv_s) begin
            start_go = 1'b1;
          end else begin
            st_nxt = ADCBUS_ST_WAIT;
          end
        end
      end
      ADCBUS_ST_WAIT: begin
        pdn_nxt = pd_s;
        if (!pd_s && cnv_fall) begin
          start_go = 1'b1;
        end
      end
      ADCBUS_ST_CONV: begin
        // pd during conversion lets it complete
        if (cnt_r >= 16'(CONV_CYC - 1)) begin
          result_nxt = held_r;
          st_nxt = ADCBUS_ST_ACQ;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: begin
        st_nxt = ADCBUS_ST_ACQ;
        cnt_nxt = 16'h0000;
      end
    endcase
    if (start_go) begin
      held_nxt = sample_in;
      st_nxt = ADCBUS_ST_CONV;
      cnt_nxt = 16'h0000;
      pdn_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= ADCBUS_ST_ACQ;
      cnt_r <= 16'h0000;
      result_r <= `ADCBUS_RESULT_RST;
      held_r <= `ADCBUS_RESULT_RST;
      pdn_r <= 1'b0;
      cnv_prev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
      held_r <= held_nxt;
      pdn_r <= pdn_nxt;
      cnv_prev_r <= cnv_prev_nxt;
    end
  end

  assign busy = (st_r == ADCBUS_ST_CONV);
  assign powered_down = pdn_r;
  assign refbuf_en = ~refbuf_off;

  // ------------------------------------------------------------
  // output bus formatter
  // ------------------------------------------------------------
  adcbus_fmt_e fmt;
  logic [17:0] coded, dnext, oenext;
  logic rd_en;
  adcbus_bus_s bus_r, bus_nxt;
  assign fmt = adcbus_fmt_e'({sel.iface_sel_hi, sel.iface_sel_lo});
  assign rd_en = ~sel.cs_n & ~sel.rd_n;

  always_comb begin
    // msb flip gives two's complement; full width is always binary
    coded = result_r;
    if (fmt != ADCBUS_FMT_PAR18 && !coding_s) begin
      coded = {~result_r[17], result_r[16:0]};
    end
    dnext = 18'h00000;
    oenext = 18'h00000;
    unique case (fmt)
      ADCBUS_FMT_PAR18: begin
        dnext = coded;
        oenext = 18'h3FFFF;
      end
      ADCBUS_FMT_PAR16: begin
        oenext = 18'h3FFFC;
        if (!wsel_s) begin
          dnext = {coded[17:2], 2'h0};
        end else begin
          dnext = {14'h0000, coded[1:0], 2'h0};
        end
      end
      ADCBUS_FMT_PAR8: begin
        oenext = 18'h3FC00;
        unique case ({wsel_s, bsel_s})
          2'b00: dnext = {coded[17:10], 10'h000};
          2'b01: dnext = {coded[9:2], 10'h000};
          default: dnext = {coded[1:0], 6'h00, 10'h000};
        endcase
      end
      ADCBUS_FMT_SERIAL: begin
        // serial port not built here; lines 0..17 stay off
        oenext = 18'h00000;
      end
    endcase
    bus_nxt.dout = dnext;
    bus_nxt.oe = rd_en ? oenext : 18'h00000;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_r <= '0;
    end else begin
      bus_r <= bus_nxt;
    end
  end
  assign bus = bus_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_busy_len: assert property ($rose(busy) |-> busy [*8])
    else $error("busy shorter than conversion");
  a_pd_nostart: assert property (!busy && pd_s |=> !busy)
    else $error("conversion started in power-down");
  a_edge_start: assert property (st_r == ADCBUS_ST_WAIT && !pd_s && cnv_fall |=> busy)
    else $error("falling edge did not start");
  a_low_start: assert property (st_r == ADCBUS_ST_ACQ && acq_done && !pd_s && !cnv_s
    |=> busy)
    else $error("low start did not convert");
  a_refbuf: assert property (refbuf_en == !refbuf_off)
    else $error("reference buffer level wrong");
  a_result_hold: assert property (!$fell(busy) |-> $stable(result_r))
    else $error("result changed without completion");
  a_bus_gate: assert property (sel.cs_n || sel.rd_n |=> bus.oe == 18'h00000)
    else $error("bus driven without cs and rd");
  a_ser_float: assert property (fmt == ADCBUS_FMT_SERIAL |=> bus.oe == 18'h00000)
    else $error("lines driven in serial format");
  a_full_word: assert property (fmt == ADCBUS_FMT_PAR18 |=> bus.dout == $past(result_r))
    else $error("full word mismatch");

  a_high_word: assert property (fmt == ADCBUS_FMT_PAR16 && !wsel_s && coding_s
    |-> dnext == {result_r[17:2], 2'h0})
    else $error("high word mismatch");
  a_low_word: assert property (fmt == ADCBUS_FMT_PAR16 && wsel_s
    |-> dnext == {14'h0000, result_r[1:0], 2'h0})
    else $error("low word mismatch");
  a_byte_hi: assert property (fmt == ADCBUS_FMT_PAR8 && !wsel_s && !bsel_s && coding_s
    |-> dnext == {result_r[17:10], 10'h000})
    else $error("high byte mismatch");
  a_byte_mid: assert property (fmt == ADCBUS_FMT_PAR8 && !wsel_s && bsel_s
    |-> dnext == {result_r[9:2], 10'h000})
    else $error("middle byte mismatch");
  a_byte_lo: assert property (fmt == ADCBUS_FMT_PAR8 && wsel_s
    |-> dnext == {result_r[1:0], 16'h0000})
    else $error("low byte mismatch");
  a_byte_float: assert property (fmt == ADCBUS_FMT_PAR8 |=> bus.oe[9:0] == 10'h000)
    else $error("low lines driven in byte format");
  a_ctl_lines: assert property (fmt != ADCBUS_FMT_PAR18 |=> bus.oe[1:0] == 2'h0)
    else $error("select lines driven outside full width");
  a_bin_code: assert property (fmt == ADCBUS_FMT_PAR18 || coding_s |-> coded == result_r)
    else $error("binary coding altered result");
  a_twos_msb: assert property (fmt != ADCBUS_FMT_PAR18 && !coding_s
    |-> coded == (result_r ^ 18'h20000))
    else $error("two's complement coding wrong");
  a_busy_start: assert property (start_go |=> busy && held_r == $past(sample_in))
    else $error("start did not raise busy with sample");
  a_result_load: assert property ($fell(busy) |-> result_r == held_r)
    else $error("result not latched at busy fall");
  a_pd_flag: assert property (st_r != ADCBUS_ST_CONV && pd_s |=> powered_down)
    else $error("power-down state not entered");
  a_wait_edge: assert property (st_r == ADCBUS_ST_WAIT && cnv_s |=> !busy)
    else $error("started without a falling edge");
  a_conv_hold: assert property (busy |=> $stable(held_r))
    else $error("held sample changed during conversion");

  // ------------------------------------------------------------
  // busy and acquisition span monitors
  // ------------------------------------------------------------
  logic [15:0] busy_cnt_r, busy_cnt_nxt;
  logic [15:0] idle_cnt_r, idle_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = 16'h0000;
    idle_cnt_nxt = idle_cnt_r;
    if (busy) begin
      busy_cnt_nxt = busy_cnt_r + 16'h0001;
      idle_cnt_nxt = 16'h0000;
    end else if (idle_cnt_r != 16'hFFFF) begin
      // saturate so a long idle spell never wraps to a small count
      idle_cnt_nxt = idle_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 16'h0000;
      idle_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  a_busy_exact: assert property ($fell(busy) |-> busy_cnt_r == 16'(CONV_CYC))
    else $error("busy length differs from conversion time");
  a_acq_gap: assert property ($rose(busy) |-> idle_cnt_r >= 16'(ACQ_CYC))
    else $error("conversion started before acquisition end");

  c_edge_conv: cover property (st_r == ADCBUS_ST_WAIT ##1 busy);
  c_byte_read: cover property (rd_en && fmt == ADCBUS_FMT_PAR8);
  c_pd_enter: cover property ($rose(powered_down));
  c_low_start: cover property (st_r == ADCBUS_ST_ACQ && acq_done && !cnv_s && !pd_s);
  c_word_read: cover property (rd_en && fmt == ADCBUS_FMT_PAR16);
endmodule // adcbus_top

// [dv/adc_conversion_start_and_output_bus_mux_tb.sv]
`timescale 1ns/10ps
module adc_conversion_start_and_output_bus_mux_tb;
  import adcbus_pkg::*;
  localparam int CONV = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic power_down_in = 1'b0;
  logic conv_start_n = 1'b1;
  logic refbuf_off = 1'b0;
  adcbus_sel_s sel = 4'hF;
  logic coding_sel = 1'b1;
  logic word_sel = 1'b0;
  logic byte_sel = 1'b0;
  logic [17:0] data_in;
  logic [17:0] sample_in = 18'h00000;
  logic [17:0] r = 18'h00000;
  adcbus_bus_s bus;
  logic busy;
  logic refbuf_en;
  logic powered_down;
  int errors = 0;
  int cmp_count = 0;
  int len;
  adcbus_top #(.ACQ_CYC(2), .CONV_CYC(CONV)) u_adcbus_top (.mclk(mclk), .rst(rst),
    .power_down_in(power_down_in), .conv_start_n(conv_start_n), .refbuf_off(refbuf_off),
    .sel(sel), .data_in(data_in), .sample_in(sample_in), .bus(bus), .busy(busy),
    .refbuf_en(refbuf_en), .powered_down(powered_down));
  adcbus_host_model u_adcbus_host_model (.mclk(mclk), .bus(bus), .sel(sel),
    .coding_sel(coding_sel), .word_sel(word_sel), .byte_sel(byte_sel), .data_in(data_in));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // selects through data lines lag a few cycles, hence the wait
  task automatic rd(input logic [1:0] fmt, input logic [2:0] cwb, input logic [17:0] ed,
      input logic [17:0] eoe);
    sel = {fmt, 2'h0};
    {coding_sel, word_sel, byte_sel} = cwb;
    cyc(6);
    check("bus_oe", bus.oe, eoe);
    check("bus_dout", bus.dout & bus.oe, ed);
  endtask
  task automatic conv(input logic [17:0] smp, input logic hold, input logic abort);
    sel = 4'h0;
    sample_in = smp;
    conv_start_n = 1'b0;
    for (len = 0; busy !== 1'b1 && len < 20; len++) cyc(1);
    check("busy_rise", 18'(busy), 18'h1);
    conv_start_n = hold;
    cyc(2);
    check("held", bus.dout & bus.oe, r);
    if (abort) begin
      rst = 1'b1;
      cyc(1);
      check("busy_abort", 18'(busy), 18'h0);
      rst = 1'b0;
      r = 18'h0;
    end
    for (len = 2; busy === 1'b1 && len < 30; len++) cyc(1);
    if (!abort) check("busy_len", 18'(len), 18'(CONV));
    // return early so a start held low meets the next sample
    cyc(1);
    if (!abort) r = smp;
    check("result", bus.dout & bus.oe, r);
  endtask
  task automatic t_fmt;
    logic [17:0] t;
    t = r ^ 18'h20000;
    rd(2'h0, 3'h0, r, 18'h3FFFF);
    rd(2'h1, 3'h4, {r[17:2], 2'h0}, 18'h3FFFC);
    rd(2'h1, 3'h2, {14'h0, t[1:0], 2'h0}, 18'h3FFFC);
    rd(2'h2, 3'h0, {t[17:10], 10'h0}, 18'h3FC00);
    rd(2'h2, 3'h5, {r[9:2], 10'h0}, 18'h3FC00);
    rd(2'h2, 3'h7, {r[1:0], 16'h0}, 18'h3FC00);
    rd(2'h3, 3'h4, 18'h0, 18'h0);
    sel = 4'h1;
    cyc(3);
    check("oe_rd_high", bus.oe, 18'h0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(2);
    check("oe_rst", bus.oe, 18'h0);
    check("busy_rst", 18'(busy), 18'h0);
    refbuf_off = 1'b1;
    cyc(1);
    check("refbuf_off", 18'(refbuf_en), 18'h0);
    refbuf_off = 1'b0;
    cyc(1);
    check("refbuf_on", 18'(refbuf_en), 18'h1);
    $display("test reset done");
    conv(18'h2A5C3, 1'b1, 1'b0);
    t_fmt();
    $display("test formats done");
    conv(18'h15A5A, 1'b0, 1'b0);
    conv(18'h0ABCD, 1'b1, 1'b0);
    $display("test back to back done");
    conv(18'h3C3C3, 1'b1, 1'b1);
    $display("test abort done");
    power_down_in = 1'b1;
    cyc(5);
    conv_start_n = 1'b0;
    cyc(20);
    check("busy_pd", 18'(busy), 18'h0);
    check("pd_state", 18'(powered_down), 18'h1);
    power_down_in = 1'b0;
    // edge seen during power-down is refused; a fresh one is needed
    conv_start_n = 1'b1;
    cyc(5);
    conv(18'h3FFFF, 1'b1, 1'b0);
    $display("test power down done");
    complete_run();
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule // adc_conversion_start_and_output_bus_mux_tb

// [dv/adcbus_host_model.sv]
`timescale 1ns/10ps
module adcbus_host_model (
  input wire logic mclk,
  input wire adcbus_pkg::adcbus_bus_s bus,
  input wire adcbus_pkg::adcbus_sel_s sel,
  input wire logic coding_sel,
  input wire logic word_sel,
  input wire logic byte_sel,
  output logic [17:0] data_in
);
  import adcbus_pkg::*;
  logic [17:0] host_oe;
  logic [17:0] last_r = 18'h00000;
  // --------------------------------
  // host side of the shared data lines
  // --------------------------------
  always_comb begin
    host_oe = 18'h00000;
    if ({sel.iface_sel_hi, sel.iface_sel_lo} != 2'h0) host_oe[1:0] = 2'h3;
    if ({sel.iface_sel_hi, sel.iface_sel_lo} == 2'h2) host_oe[2] = 1'b1;
  end
  // a floating line flips each cycle so a stale level never passes
  always_ff @(posedge mclk) last_r <= data_in;
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (host_oe[i]) data_in[i] = (i == 0) ? coding_sel : (i == 1) ? word_sel : byte_sel;
      else if (bus.oe[i]) data_in[i] = bus.dout[i];
      else data_in[i] = ~last_r[i];
    end
  end
endmodule // adcbus_host_model

// [inc/adcbus_defines.svh]
`ifndef ADCBUS_DEFINES_SVH
`define ADCBUS_DEFINES_SVH
// Summary of operation
// - power-down finishes current conversion, blocks new ones
// - start high after acquisition: convert on falling edge
// - start low after acquisition: convert at once
// - refbuf_off low enables buffer, high disables it
// - latest result kept in 18-bit output register
// - format 0: all 18 bits parallel
// - format 1: high word or low word
// - format 2 byte 0: bits 17..10, lines 3-9 float
// - format 2 byte 1: bits 9..2 on 17..10
// - format 2 byte 2: bits 1..0, zeros, float
// - bus driven only while cs_n and rd_n low
// - busy high from start until result latched
// - coding select: straight binary or two's complement in formats 1 and 2; format 0 always binary
// - reset aborts conversion in progress

// ------------------------------------------------------------
// timing counts at 40 MHz (25 ns period)
// ------------------------------------------------------------
`define ADCBUS_CLK_PERIOD_NS 25
`define ADCBUS_ACQ_NS 400
`define ADCBUS_ACQ_CYC ((`ADCBUS_ACQ_NS + `ADCBUS_CLK_PERIOD_NS - 1) / `ADCBUS_CLK_PERIOD_NS)
`define ADCBUS_CONV_NS 1250
`define ADCBUS_CONV_CYC ((`ADCBUS_CONV_NS + `ADCBUS_CLK_PERIOD_NS - 1) / `ADCBUS_CLK_PERIOD_NS)

// ------------------------------------------------------------
// data bus layout and reset values
// ------------------------------------------------------------
`define ADCBUS_RES_W 18
`define ADCBUS_MSB_POS 17
`define ADCBUS_RESULT_RST 18'h00000
// conv start idles high, so leaving reset makes no false edge
`define ADCBUS_SYNC_RST 5'h08
`define ADCBUS_LINE_CODING 0
`define ADCBUS_LINE_WSEL 1
`define ADCBUS_LINE_BSEL 2
`endif

// [inc/adcbus_pkg.sv]
package adcbus_pkg;
  typedef enum logic [1:0] {
    ADCBUS_ST_ACQ = 2'b00,
    ADCBUS_ST_WAIT = 2'b01,
    ADCBUS_ST_CONV = 2'b10
  } adcbus_state_e;

  typedef enum logic [1:0] {
    ADCBUS_FMT_PAR18 = 2'b00,
    ADCBUS_FMT_PAR16 = 2'b01,
    ADCBUS_FMT_PAR8 = 2'b10,
    ADCBUS_FMT_SERIAL = 2'b11
  } adcbus_fmt_e;

  // one data bus as two signals per line
  typedef struct packed {
    logic [17:0] dout;
    logic [17:0] oe;
  } adcbus_bus_s;

  // host-side select inputs grouped
  typedef struct packed {
    logic iface_sel_hi;
    logic iface_sel_lo;
    logic cs_n;
    logic rd_n;
  } adcbus_sel_s;
endpackage
